// ---- rtl/agc_pkg.sv ----
/*
  Shared definitions for the receive gain control block: register offsets,
  field layouts, reset values, threshold steps and second amplifier gains.
  Assumes magnitudes and levels are expressed in 1.5 dB units.
*/
package agc_pkg;

  localparam logic [6:0] ADDR_GAIN_CONTROL_CONFIG          = 7'h12;
  localparam logic [6:0] ADDR_GAIN_DECREASE_AND_INITIAL    = 7'h13;
  localparam logic [6:0] ADDR_GAIN_INCREASE_AND_REFERENCE  = 7'h14;

  localparam int         MAG_W       = 8;
  localparam int         SUM_W       = 12;
  localparam int         GAIN_W      = 5;

  typedef struct packed {
    logic       second_amp_low_bound;
    logic       second_amp_high_bound;
    logic [1:0] second_amp_switch_point;
    logic       auto_gain_off;
    logic       auto_gain_two_sample_confirm;
    logic [1:0] magnitude_average_length;
  } gain_control_config_t;

  typedef struct packed {
    logic [2:0] decrease_margin;
    logic [4:0] initial_gain;
  } gain_decrease_and_initial_t;

  typedef struct packed {
    logic [2:0] increase_offset;
    logic [4:0] sense_reference;
  } gain_increase_and_reference_t;

  localparam gain_control_config_t         CONFIG_RESET   = 8'h75;
  localparam gain_decrease_and_initial_t   DECREASE_RESET = 8'h38;
  localparam gain_increase_and_reference_t INCREASE_RESET = 8'h38;

  // Decrease margin starts 4.5 dB (three 1.5 dB steps) above the increase level
  localparam logic [MAG_W-1:0]  DECREASE_BASE_STEPS = 8'h03;
  localparam logic [GAIN_W-1:0] GAIN_MIN            = 5'h00;

  // Gain settings at which the second amplifier switches, per switch-point code
  localparam logic [GAIN_W:0]   SWITCH_BELOW_MIN    = 6'h00;
  localparam logic [GAIN_W:0]   SWITCH_THIRD        = 6'h0A;
  localparam logic [GAIN_W:0]   SWITCH_TWO_THIRDS   = 6'h13;
  localparam logic [GAIN_W:0]   SWITCH_ABOVE_MAX    = 6'h20;

  typedef enum logic [1:0] {
    AMP_MIN     = 2'h0,
    AMP_MED     = 2'h1,
    AMP_MAX     = 2'h2,
    AMP_MED_MAX = 2'h3
  } second_amp_gain_t;

  typedef struct packed {
    logic             valid;
    logic [MAG_W-1:0] level;
  } strength_t;

endpackage

// ---- rtl/magnitude_averager.sv ----
/*
  Averages filter output magnitudes over 2, 4, 8 or 16 samples and emits
  one averaged strength per completed window.
  Assumes samples arrive on clk_sys with a one-cycle valid strobe.
*/
`timescale 1ns/1ps
module magnitude_averager (
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic [1:0]               average_length,
  input  wire logic                     sample_valid,
  input  wire logic [agc_pkg::MAG_W-1:0] sample_mag,
  output agc_pkg::strength_t            strength
);

  logic [3:0]               count;
  logic [agc_pkg::SUM_W-1:0] sum;
  logic [agc_pkg::SUM_W-1:0] next_sum;
  logic [3:0]               last_index;

  // Window of 2 to the power (code + 1) samples
  assign last_index = 4'((5'h02 << average_length) - 5'h01);
  assign next_sum   = sum + agc_pkg::SUM_W'(sample_mag);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count          <= 4'h0;
      sum            <= '0;
      strength       <= '0;
    end else begin
      strength.valid <= 1'b0;
      if (sample_valid) begin
        if (count >= last_index) begin
          count          <= 4'h0;
          sum            <= '0;
          strength.valid <= 1'b1;
          // Shift widened so the 16-sample code does not wrap to zero
          strength.level <= agc_pkg::MAG_W'(next_sum >> ({1'b0, average_length} + 3'h1));
        end else begin
          count <= count + 4'h1;
          sum   <= next_sum;
        end
      end
    end
  end

endmodule

// ---- rtl/carrier_sense_detect.sv ----
/*
  Carrier sense qualifier: sets after a programmed run of strengths at or
  above the reference and clears after one or two strengths below it.
  Assumes one strength per averaging window on clk_sys.
*/
`timescale 1ns/1ps
module carrier_sense_detect (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic [1:0]                set_count,
  input  wire logic                      release_two,
  input  wire logic [4:0]                reference,
  input  wire agc_pkg::strength_t        strength,
  output logic                           carrier_sense
);

  logic [1:0] above_run;
  logic       below_run;
  logic       at_or_above;

  assign at_or_above = strength.level >= agc_pkg::MAG_W'(reference);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      above_run     <= 2'h0;
      below_run     <= 1'b0;
      carrier_sense <= 1'b0;
    end else if (strength.valid) begin
      if (at_or_above) begin
        below_run <= 1'b0;
        if (above_run >= set_count) begin
          carrier_sense <= 1'b1;
        end else begin
          above_run <= above_run + 2'h1;
        end
      end else begin
        above_run <= 2'h0;
        if (below_run || !release_two) begin
          carrier_sense <= 1'b0;
          below_run     <= 1'b0;
        end else begin
          below_run <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- rtl/receive_agc_control.sv ----
/*
  Receive automatic gain control: configuration registers, averaged
  magnitude, gain stepping with optional two-sample confirmation, second
  amplifier gain selection and carrier sense.
  Assumes a register write/read port and samples on the filter clock clk_sys.
*/
`timescale 1ns/1ps
// Behaviour
// - The switch-point code puts the second amplifier change below minimum, near gain 10, near 19 or above maximum.
// - With low bound 1 and high bound 0 the switch-point code fixes the second amplifier gain instead.
// - With auto gain off the gain follows the initial gain setting, otherwise control runs.
// - Without confirmation a step is applied at once, with it two evaluations in a row must agree.
// - The averaging code selects 2, 4, 8 or 16 samples per averaged strength.
// - Gain drops when strength exceeds reference plus increase offset plus a 4.5 to 15 dB margin.
// - The initial gain, reset 24, loads at receive power-on and caps automatic gain.
// - Below its cap, gain rises when strength falls below reference plus a 0 to 10.5 dB offset.
// - The sense reference, reset 24, is shared by carrier sense and gain thresholds.
// - Carrier sense sets after one to four averaged strengths at or above reference and clears after one or two below.
// - The bound bits pick minimum or medium as low and medium or maximum as high second amplifier gain.
module receive_agc_control (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic                      cfg_write,
  input  wire logic [6:0]                cfg_addr,
  input  wire logic [7:0]                cfg_wdata,
  output logic      [7:0]                cfg_rdata,
  input  wire logic [1:0]                sense_set_count,
  input  wire logic                      sense_release_two,
  input  wire logic                      rx_on,
  input  wire logic                      sample_valid,
  input  wire logic [agc_pkg::MAG_W-1:0] sample_mag,
  output logic      [4:0]                gain,
  output agc_pkg::second_amp_gain_t      second_amp_gain,
  output logic                           carrier_sense,
  output agc_pkg::strength_t             strength
);

  agc_pkg::gain_control_config_t         config_reg;
  agc_pkg::gain_decrease_and_initial_t   decrease_reg;
  agc_pkg::gain_increase_and_reference_t increase_reg;

  agc_pkg::strength_t          average;
  logic                        rx_on_last;
  logic                        want_up;
  logic                        want_down;
  logic                        pending_up;
  logic                        pending_down;
  logic [agc_pkg::MAG_W-1:0]   up_level;
  logic [agc_pkg::MAG_W-1:0]   down_level;
  logic [agc_pkg::GAIN_W:0]    switch_at;
  agc_pkg::second_amp_gain_t   next_second_amp_gain;
  logic [4:0]                  next_gain;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      config_reg   <= agc_pkg::CONFIG_RESET;
      decrease_reg <= agc_pkg::DECREASE_RESET;
      increase_reg <= agc_pkg::INCREASE_RESET;
    end else if (cfg_write) begin
      unique case (cfg_addr)
        agc_pkg::ADDR_GAIN_CONTROL_CONFIG:         config_reg   <= cfg_wdata;
        agc_pkg::ADDR_GAIN_DECREASE_AND_INITIAL:   decrease_reg <= cfg_wdata;
        agc_pkg::ADDR_GAIN_INCREASE_AND_REFERENCE: increase_reg <= cfg_wdata;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_rdata <= 8'h00;
    end else begin
      unique case (cfg_addr)
        agc_pkg::ADDR_GAIN_CONTROL_CONFIG:         cfg_rdata <= config_reg;
        agc_pkg::ADDR_GAIN_DECREASE_AND_INITIAL:   cfg_rdata <= decrease_reg;
        agc_pkg::ADDR_GAIN_INCREASE_AND_REFERENCE: cfg_rdata <= increase_reg;
        default:                                   cfg_rdata <= 8'h00;
      endcase
    end
  end

  magnitude_averager averager (
    .clk_sys        (clk_sys),
    .reset          (reset),
    .average_length (config_reg.magnitude_average_length),
    .sample_valid   (sample_valid),
    .sample_mag     (sample_mag),
    .strength       (average)
  );

  carrier_sense_detect sense (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .set_count     (sense_set_count),
    .release_two   (sense_release_two),
    .reference     (increase_reg.sense_reference),
    .strength      (average),
    .carrier_sense (carrier_sense)
  );

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strength <= '0;
    end else begin
      strength <= average;
    end
  end

  assign up_level   = agc_pkg::MAG_W'(increase_reg.sense_reference)
                    + agc_pkg::MAG_W'(increase_reg.increase_offset);
  assign down_level = up_level + agc_pkg::DECREASE_BASE_STEPS
                    + agc_pkg::MAG_W'(decrease_reg.decrease_margin);

  assign want_up   = average.level < up_level && gain < decrease_reg.initial_gain;
  assign want_down = average.level > down_level && gain > agc_pkg::GAIN_MIN;

  always_comb begin
    next_gain = gain;
    if (want_up) begin
      next_gain = gain + 5'h01;
    end else if (want_down) begin
      next_gain = gain - 5'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_on_last <= 1'b0;
    end else begin
      rx_on_last <= rx_on;
    end
  end

  // Direction remembered across windows for the confirmation step
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pending_up   <= 1'b0;
      pending_down <= 1'b0;
    end else if (config_reg.auto_gain_off || (rx_on && !rx_on_last)) begin
      pending_up   <= 1'b0;
      pending_down <= 1'b0;
    end else if (average.valid) begin
      pending_up   <= want_up;
      pending_down <= want_down;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gain <= agc_pkg::DECREASE_RESET.initial_gain;
    end else if (config_reg.auto_gain_off) begin
      gain <= decrease_reg.initial_gain;
    end else if (rx_on && !rx_on_last) begin
      gain <= decrease_reg.initial_gain;
    end else if (gain > decrease_reg.initial_gain) begin
      gain <= decrease_reg.initial_gain;
    end else if (average.valid && rx_on) begin
      if (!config_reg.auto_gain_two_sample_confirm
          || (want_up && pending_up) || (want_down && pending_down)) begin
        gain <= next_gain;
      end
    end
  end

  // switch point along the gain range
  always_comb begin
    unique case (config_reg.second_amp_switch_point)
      2'h0:    switch_at = agc_pkg::SWITCH_BELOW_MIN;
      2'h1:    switch_at = agc_pkg::SWITCH_THIRD;
      2'h2:    switch_at = agc_pkg::SWITCH_TWO_THIRDS;
      default: switch_at = agc_pkg::SWITCH_ABOVE_MAX;
    endcase
  end

  always_comb begin
    if (config_reg.second_amp_low_bound && !config_reg.second_amp_high_bound) begin
      unique case (config_reg.second_amp_switch_point)
        2'h0:    next_second_amp_gain = agc_pkg::AMP_MED_MAX;
        2'h1:    next_second_amp_gain = agc_pkg::AMP_MIN;
        2'h2:    next_second_amp_gain = agc_pkg::AMP_MED;
        default: next_second_amp_gain = agc_pkg::AMP_MAX;
      endcase
    // high bound at or above switch point
    end else if ({1'b0, gain} >= switch_at) begin
      next_second_amp_gain = config_reg.second_amp_high_bound ? agc_pkg::AMP_MAX
                                                              : agc_pkg::AMP_MED;
    end else begin
      next_second_amp_gain = config_reg.second_amp_low_bound ? agc_pkg::AMP_MED
                                                             : agc_pkg::AMP_MIN;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      second_amp_gain <= agc_pkg::AMP_MIN;
    end else begin
      second_amp_gain <= next_second_amp_gain;
    end
  end

endmodule

// ---- bench/agc_sva.sv ----
/* Checker bound to receive_agc_control.
   Assumes registers change only through the write port. */
`timescale 1ns/1ps
module agc_sva (
  input wire logic                      clk_sys,
  input wire logic                      reset,
  input wire logic                      cfg_write,
  input wire logic [6:0]                cfg_addr,
  input wire logic [7:0]                cfg_wdata,
  input wire logic [7:0]                cfg_rdata,
  input wire logic                      rx_on,
  input wire logic [4:0]                gain,
  input wire agc_pkg::second_amp_gain_t second_amp_gain,
  input wire logic                      carrier_sense,
  input wire agc_pkg::strength_t        strength
);
  logic [7:0] r12;
  logic [7:0] r13;
  logic [7:0] r14;
  logic [7:0] rd;
  logic [7:0] up_t;
  logic [7:0] dn_t;
  logic [5:0] thr;
  logic [1:0] amp;
  logic       rx_q;
  logic       ok;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r12 <= agc_pkg::CONFIG_RESET;
      r13 <= agc_pkg::DECREASE_RESET;
      r14 <= agc_pkg::INCREASE_RESET;
    end else if (cfg_write) begin
      if (cfg_addr == agc_pkg::ADDR_GAIN_CONTROL_CONFIG) r12 <= cfg_wdata;
      if (cfg_addr == agc_pkg::ADDR_GAIN_DECREASE_AND_INITIAL) r13 <= cfg_wdata;
      if (cfg_addr == agc_pkg::ADDR_GAIN_INCREASE_AND_REFERENCE) r14 <= cfg_wdata;
    end
  end
  // Confirm mode skipped: one window alone does not fix its outcome
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_q <= 1'b0;
      ok   <= 1'b0;
    end else begin
      rx_q <= rx_on;
      ok   <= rx_on && rx_q && !r12[3] && !r12[2];
    end
  end
  always_comb begin
    case (cfg_addr)
      agc_pkg::ADDR_GAIN_CONTROL_CONFIG:         rd = r12;
      agc_pkg::ADDR_GAIN_DECREASE_AND_INITIAL:   rd = r13;
      agc_pkg::ADDR_GAIN_INCREASE_AND_REFERENCE: rd = r14;
      default:                                   rd = 8'h00;
    endcase
    case (r12[5:4])
      2'h0:    thr = agc_pkg::SWITCH_BELOW_MIN;
      2'h1:    thr = agc_pkg::SWITCH_THIRD;
      2'h2:    thr = agc_pkg::SWITCH_TWO_THIRDS;
      default: thr = agc_pkg::SWITCH_ABOVE_MAX;
    endcase
    if ({1'b0, gain} >= thr) begin
      amp = r12[6] ? agc_pkg::AMP_MAX : agc_pkg::AMP_MED;
    end else begin
      amp = r12[7] ? agc_pkg::AMP_MED : agc_pkg::AMP_MIN;
    end
  end
  assign up_t = {3'h0, r14[4:0]} + {5'h00, r14[7:5]};
  assign dn_t = up_t + agc_pkg::DECREASE_BASE_STEPS + {5'h00, r13[7:5]};
  chk_off_follow: assert property (r12[3] |=> gain == $past(r13[4:0]))
    else $error("gain differs from initial setting with control off");
  chk_rx_load: assert property ($rose(rx_on) |=> gain == $past(r13[4:0]))
    else $error("initial gain not loaded at receive on");
  chk_gain_down: assert property (strength.valid && ok && strength.level > $past(dn_t)
    && $past(gain) != 5'h00 && $past(gain) <= $past(r13[4:0])
    |-> gain == $past(gain) - 5'h01)
    else $error("gain did not step down on strong window");
  chk_gain_up: assert property (strength.valid && ok && strength.level < $past(up_t)
    && $past(gain) < $past(r13[4:0]) |-> gain == $past(gain) + 5'h01)
    else $error("gain did not step up on weak window");
  chk_amp_fixed: assert property (r12[7:6] == 2'b10
    |=> second_amp_gain == $past(r12[5:4]) - 2'h1)
    else $error("fixed second amplifier gain wrong");
  chk_amp_auto: assert property (r12[7:6] != 2'b10 |=> second_amp_gain == $past(amp))
    else $error("second amplifier switch point wrong");
  chk_sense_set: assert property ($rose(carrier_sense) |-> strength.valid
    && strength.level >= {3'h0, $past(r14[4:0])})
    else $error("carrier sense set below reference");
  chk_read_back: assert property (!cfg_write && !$past(cfg_write) |=> cfg_rdata == $past(rd))
    else $error("register read data wrong");
  cover property (strength.valid && ok && gain != $past(gain));
  cover property ($fell(carrier_sense));
  cover property (r12[7:6] == 2'b10 && r12[5:4] == 2'h0);
endmodule
bind receive_agc_control agc_sva u_chk (
  .clk_sys(clk_sys), .reset(reset), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .rx_on(rx_on), .gain(gain),
  .second_amp_gain(second_amp_gain), .carrier_sense(carrier_sense), .strength(strength)
);

// ---- bench/front_end_model.sv ----
/* Filter output sample source standing in for the analog front end.
   Assumes the bench sets level and spacing between samples. */
`timescale 1ns/1ps
module front_end_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] level,
  input  wire logic [1:0] gap,
  output logic            sample_valid,
  output logic [7:0]      sample_mag
);
  logic [1:0] cnt;
  // Between samples the bus toggles, never a stale value
  always_ff @(negedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt          <= 2'h0;
      sample_valid <= 1'b0;
      sample_mag   <= 8'h00;
    end else if (cnt >= gap) begin
      cnt          <= 2'h0;
      sample_valid <= 1'b1;
      sample_mag   <= level;
    end else begin
      cnt          <= cnt + 2'h1;
      sample_valid <= 1'b0;
      sample_mag   <= ~sample_mag;
    end
  end
endmodule

// ---- bench/tb_top.sv ----
/* Self-checking bench for receive_agc_control.
   Assumes a 100 MHz clock and inputs driven on falling edges. */
`timescale 1ns/1ps
module tb_top;
  logic                      clk_sys = 1'b0;
  logic                      reset = 1'b1;
  logic                      cfg_write = 1'b0;
  logic [6:0]                cfg_addr = 7'h00;
  logic [7:0]                cfg_wdata = 8'h00;
  logic [7:0]                cfg_rdata;
  logic [1:0]                set_n = 2'h1;
  logic                      rel2 = 1'b0;
  logic                      rx_on = 1'b0;
  logic                      sample_valid;
  logic [7:0]                sample_mag;
  logic [7:0]                level = 8'h00;
  logic [1:0]                gap = 2'h0;
  logic [4:0]                gain;
  agc_pkg::second_amp_gain_t second_amp_gain;
  logic                      carrier_sense;
  agc_pkg::strength_t        strength;
  int                        error_cnt = 0;
  int                        check_count = 0;
  int                        n;
  always #5 clk_sys = ~clk_sys;
  front_end_model u_fe (.clk_sys(clk_sys), .reset(reset), .level(level), .gap(gap),
    .sample_valid(sample_valid), .sample_mag(sample_mag));
  receive_agc_control DUT (.clk_sys(clk_sys), .reset(reset), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .sense_set_count(set_n), .sense_release_two(rel2), .rx_on(rx_on),
    .sample_valid(sample_valid), .sample_mag(sample_mag), .gain(gain),
    .second_amp_gain(second_amp_gain), .carrier_sense(carrier_sense), .strength(strength));
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    cfg_addr = a;
    cfg_wdata = v;
    cfg_write = 1'b1;
    @(negedge clk_sys);
    cfg_write = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    cfg_addr = a;
    repeat (2) @(negedge clk_sys);
    check(cfg_rdata, exp);
  endtask
  // Bounded wait for a number of averaged windows
  task automatic wins(input int w);
    int k;
    k = 0;
    while (w > 0) begin
      @(negedge clk_sys);
      k++;
      if (strength.valid === 1'b1) w--;
      if (k > 2000) begin
        error_cnt++;
        close_out();
      end
    end
  endtask
  // Receive off while the level settles, then on from the initial gain of 2
  task automatic run(input logic [7:0] lv, input int w, input logic [4:0] exp);
    wr(7'h13, 8'h02);
    rx_on = 1'b0;
    level <= lv;
    wins(2);
    rx_on = 1'b1;
    wins(w);
    check({3'h0, gain}, {3'h0, exp});
  endtask
  task automatic amp(input logic [7:0] c12, input logic [7:0] c13, input logic [1:0] exp);
    wr(7'h12, c12);
    wr(7'h13, c13);
    repeat (3) @(negedge clk_sys);
    check({6'h00, second_amp_gain}, {6'h00, exp});
  endtask
  task automatic cs(input logic [7:0] lv, input int w, input logic exp);
    level <= lv;
    wins(w);
    check({7'h00, carrier_sense}, {7'h00, exp});
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    check({3'h0, gain}, 8'h18);
    rd(7'h12, 8'h75);
    rd(7'h13, 8'h38);
    rd(7'h14, 8'h38);
    rd(7'h15, 8'h00);
    $display("registers done");
    wr(7'h12, 8'h70);
    run(8'hF0, 1, 5'h01);
    run(8'hF0, 3, 5'h00);
    run(8'h1D, 1, 5'h01);
    run(8'h1C, 2, 5'h02);
    run(8'h19, 1, 5'h02);
    wr(7'h13, 8'h04);
    wins(2);
    check({3'h0, gain}, 8'h02);
    run(8'h18, 1, 5'h02);
    wr(7'h13, 8'h04);
    wins(1);
    check({3'h0, gain}, 8'h03);
    wins(2);
    check({3'h0, gain}, 8'h04);
    wr(7'h12, 8'h74);
    run(8'hF0, 1, 5'h02);
    wins(1);
    check({3'h0, gain}, 8'h01);
    wr(7'h12, 8'h78);
    wr(7'h13, 8'h07);
    wins(2);
    check({3'h0, gain}, 8'h07);
    $display("gain done");
    gap <= 2'h1;
    for (int i = 0; i < 4; i++) begin
      wr(7'h12, 8'h78 | i[7:0]);
      wins(2);
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (strength.valid !== 1'b1 && n < 99);
      check(8'(n), 8'(4 << i));
      check(strength.level, level);
      if (n >= 99) begin
        close_out();
      end
    end
    gap <= 2'h0;
    $display("average done");
    amp(8'h58, 8'h0A, 2'h2);
    amp(8'h58, 8'h09, 2'h0);
    amp(8'hD8, 8'h09, 2'h1);
    amp(8'h18, 8'h0A, 2'h1);
    for (int i = 0; i < 4; i++) begin
      amp({2'b10, i[1:0], 4'h8}, 8'h0A, 2'(i - 1));
    end
    amp(8'h68, 8'h12, 2'h0);
    amp(8'h68, 8'h13, 2'h2);
    amp(8'h48, 8'h00, 2'h2);
    amp(8'hF8, 8'h1F, 2'h1);
    $display("second amp done");
    // Short window and counts so sense settles quickly
    wr(7'h12, 8'h78);
    cs(8'h00, 3, 1'b0);
    cs(8'h18, 2, 1'b0);
    cs(8'h18, 1, 1'b1);
    cs(8'h17, 2, 1'b0);
    set_n = 2'h3;
    cs(8'h18, 4, 1'b0);
    cs(8'h18, 1, 1'b1);
    rel2 = 1'b1;
    cs(8'h17, 2, 1'b1);
    cs(8'h17, 1, 1'b0);
    set_n = 2'h0;
    rel2 = 1'b0;
    cs(8'h18, 2, 1'b1);
    $display("sense done");
    close_out();
  end
endmodule
